// >>> verilog/tmr3_pkg.sv
// package: register map, field positions and carrier types for the 16-bit timer
package tmr3_pkg;
  // register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_COUNT_LO  = 8'h04;
  localparam logic [7:0] ADDR_COUNT_HI  = 8'h08;
  localparam logic [7:0] ADDR_IRQ       = 8'h0C;
  localparam logic [7:0] ADDR_AUX       = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  // control field positions
  localparam int CTL_RUN     = 0;
  localparam int CTL_SRC     = 1;
  localparam int CTL_NOSYNC  = 2;
  localparam int CTL_TB_LO   = 3;
  localparam int CTL_PS_LO   = 4;
  localparam int CTL_PS_HI   = 5;
  localparam int CTL_TB_HI   = 6;
  localparam int CTL_WIDE    = 7;
  // irq register fields
  localparam int IRQ_FLAG    = 0;
  localparam int IRQ_EN      = 1;
  localparam logic [7:0]  CTL_RESET   = 8'h00;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO  = 16'h0000;
  localparam logic [3:0]  SPEC_TRIG_MODE = 4'hb;
  localparam int INSTR_DIV   = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [3:0] mode_a;
    logic [3:0] mode_b;
    logic       uses_a;
    logic       uses_b;
    logic       trig_a;
    logic       trig_b;
  } tmr3_ccp_t;

  typedef struct packed {
    logic [15:0] count;
    logic        src_a_this;
    logic        src_b_this;
  } tmr3_tbase_t;
endpackage : tmr3_pkg

// >>> verilog/tmr3_timer.sv
// 16-bit timer/counter with prescaler, wide access buffer and AHB-Lite registers
// Overview of operation
// RL1 - wide mode: 16-bit access, else byte registers
// RL2 - timebase select routes timer to compare units
// RL3 - prescale select divides by 1,2,4,8
// RL4 - sync-disable bypasses external synchroniser; code skips only raw_prev_reg, ext_s2_reg still two flops
// RL5 - external counts rising edge after first fall
// RL6 - run bit enables counting, clear holds value
// RL7 - internal source counts once per instruction cycle
// RL8 - aux oscillator forces pins input, reads zero
// RL9 - low byte read copies high into buffer
// RL10 - high write buffers; low write loads both
// RL11 - wide mode high byte only via buffer
// RL12 - low byte write clears prescaler only
// RL13 - software sets aux enable and external source
// RL14 - count up, wrap sets sticky overflow flag
// RL15 - interrupt request only when enable set
// RL16 - special event trigger zeroes the counter
// RL17 - trigger reset skipped in async counter mode
// RL18 - software write beats trigger reset
// RL19 - trigger reset never sets overflow flag
// RL20 - reset clears control register to zero
`timescale 1ns/1ps
module tmr3_timer #(
  parameter int CLK_MHZ = 100
) (
  // clock and reset
  input  wire logic                 MCLK_I,
  input  wire logic                 ARST_N_I,
  // ahb-lite slave
  input  wire logic                 HSEL_I,
  input  wire logic [7:0]           HADDR_I,
  input  wire logic [1:0]           HTRANS_I,
  input  wire logic                 HWRITE_I,
  input  wire logic [2:0]           HSIZE_I,
  input  wire logic [31:0]          HWDATA_I,
  input  wire logic                 HREADY_I,
  output logic      [31:0]          HRDATA_O,
  output logic                      HREADYOUT_O,
  output logic                      HRESP_O,
  // external count pin and shared oscillator pins
  input  wire logic                 EXT_COUNT_I,
  input  wire logic [1:0]           OSC_PIN_I,
  input  wire logic [1:0]           PORT_C_DIRECTION_I,
  input  wire logic [1:0]           PORT_OUT_I,
  output logic      [1:0]           OSC_PIN_O,
  output logic      [1:0]           OSC_PIN_OE_O,
  output logic      [1:0]           PORT_READ_O,
  // capture/compare units
  input  wire tmr3_pkg::tmr3_ccp_t  CCP_I,
  input  wire logic [15:0]          OTHER_COUNT_I,
  output tmr3_pkg::tmr3_tbase_t     TBASE_O,
  output logic [15:0]               CCP_A_COUNT_O,
  output logic [15:0]               CCP_B_COUNT_O,
  // interrupt request
  output logic                      OVF_IRQ_O
);
  logic [7:0]  ctl_reg;
  logic [15:0] count_reg;
  logic [7:0]  hi_buf_reg;
  logic        ovf_flag_reg;
  logic        ovf_en_reg;
  logic        aux_osc_en_reg;
  logic [2:0]  presc_reg;
  logic [1:0]  div4_reg;
  logic        ext_s1_reg, ext_s2_reg, ext_prev_reg, ext_armed_reg;
  logic        raw_prev_reg;
  // bus data phase
  logic        dp_wr_reg, dp_rd_reg;
  logic [7:0]  dp_addr_reg;
  logic [31:0] rdata_reg;

  wire wide   = ctl_reg[tmr3_pkg::CTL_WIDE];
  wire run    = ctl_reg[tmr3_pkg::CTL_RUN];
  wire ext    = ctl_reg[tmr3_pkg::CTL_SRC];
  wire nosync = ctl_reg[tmr3_pkg::CTL_NOSYNC];
  wire [1:0] ps = {ctl_reg[tmr3_pkg::CTL_PS_HI], ctl_reg[tmr3_pkg::CTL_PS_LO]};
  wire async_mode = ext & nosync;

  // ---------------- bus slave ----------------
  wire addr_ph = HSEL_I & HREADY_I & (HTRANS_I == tmr3_pkg::HTRANS_NONSEQ);
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = rdata_reg;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dp_wr_reg   <= 1'b0;
      dp_rd_reg   <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else begin
      dp_wr_reg   <= addr_ph & HWRITE_I;
      dp_rd_reg   <= addr_ph & ~HWRITE_I;
      dp_addr_reg <= HADDR_I;
    end
  end

  wire wr_ctl = dp_wr_reg & (dp_addr_reg == tmr3_pkg::ADDR_CONTROL);
  wire wr_lo  = dp_wr_reg & (dp_addr_reg == tmr3_pkg::ADDR_COUNT_LO);
  wire wr_hi  = dp_wr_reg & (dp_addr_reg == tmr3_pkg::ADDR_COUNT_HI);
  wire wr_irq = dp_wr_reg & (dp_addr_reg == tmr3_pkg::ADDR_IRQ);
  wire wr_aux = dp_wr_reg & (dp_addr_reg == tmr3_pkg::ADDR_AUX);
  wire rd_lo  = addr_ph & ~HWRITE_I & (HADDR_I == tmr3_pkg::ADDR_COUNT_LO);
  wire [7:0] wbyte = HWDATA_I[7:0];

  // read data is formed in the address phase and stands in the data phase
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_reg <= 32'h0000_0000;
    end else if (addr_ph & ~HWRITE_I) begin
      case (HADDR_I)
        tmr3_pkg::ADDR_CONTROL:  rdata_reg <= {24'h00_0000, ctl_reg};
        tmr3_pkg::ADDR_COUNT_LO: rdata_reg <= {24'h00_0000, count_reg[7:0]};
        tmr3_pkg::ADDR_COUNT_HI: rdata_reg <= {24'h00_0000,
                                   wide ? hi_buf_reg : count_reg[15:8]}; // see RL11
        tmr3_pkg::ADDR_IRQ:      rdata_reg <= {30'h0000_0000, ovf_en_reg, ovf_flag_reg};
        tmr3_pkg::ADDR_AUX:      rdata_reg <= {31'h0000_0000, aux_osc_en_reg};
        tmr3_pkg::ADDR_STATUS:   rdata_reg <= {16'h0000, count_reg};
        default:                 rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctl_reg <= tmr3_pkg::CTL_RESET; // see RL20
    end else if (wr_ctl) begin
      ctl_reg <= wbyte;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      aux_osc_en_reg <= 1'b0;
      ovf_en_reg     <= 1'b0;
    end else begin
      if (wr_aux) aux_osc_en_reg <= wbyte[0];
      if (wr_irq) ovf_en_reg <= wbyte[tmr3_pkg::IRQ_EN];
    end
  end

  // ---------------- shared oscillator pins ----------------
  assign OSC_PIN_OE_O = aux_osc_en_reg ? 2'b00 : ~PORT_C_DIRECTION_I; // see RL8
  assign OSC_PIN_O    = PORT_OUT_I;
  logic [1:0] pin_s1_reg, pin_s2_reg;
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pin_s1_reg <= 2'b00;
      pin_s2_reg <= 2'b00;
    end else begin
      pin_s1_reg <= OSC_PIN_I;
      pin_s2_reg <= pin_s1_reg;
    end
  end
  assign PORT_READ_O = aux_osc_en_reg ? 2'b00 : pin_s2_reg; // see RL8

  // ---------------- count clock source ----------------
  // aux oscillator shares the external count path (see RL13)
  wire ext_src = aux_osc_en_reg ? pin_s2_reg[0] : EXT_COUNT_I;
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_src;
      ext_s2_reg <= ext_s1_reg;
    end
  end
  // unsynchronised path still sampled twice, through ext_s1_reg and ext_s2_reg
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      raw_prev_reg <= 1'b0;
    end else begin
      raw_prev_reg <= ext_s2_reg;
    end
  end
  wire ext_level = nosync ? ext_s2_reg : raw_prev_reg; // see RL4

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ext_prev_reg  <= 1'b0;
      ext_armed_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_level;
      if (!ext || !run) ext_armed_reg <= 1'b0;
      else if (ext_prev_reg & ~ext_level) ext_armed_reg <= 1'b1; // see RL5
    end
  end
  wire ext_tick = ext_armed_reg & ~ext_prev_reg & ext_level; // see RL5

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      div4_reg <= 2'b00;
    end else begin
      div4_reg <= div4_reg + 2'b01;
    end
  end
  wire int_tick = (div4_reg == 2'(tmr3_pkg::INSTR_DIV - 1)); // see RL7
  wire src_tick = run & (ext ? ext_tick : int_tick); // see RL6 RL7

  // ---------------- prescaler ----------------
  logic ps_tick;
  always_comb begin
    case (ps) // see RL3
      2'b00:   ps_tick = src_tick;
      2'b01:   ps_tick = src_tick & (presc_reg[0] == 1'b1);
      2'b10:   ps_tick = src_tick & (presc_reg[1:0] == 2'b11);
      default: ps_tick = src_tick & (presc_reg == 3'b111);
    endcase
  end
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      presc_reg <= 3'b000;
    end else if (wr_lo) begin
      presc_reg <= 3'b000; // see RL12
    end else if (src_tick) begin
      presc_reg <= presc_reg + 3'b001;
    end
  end

  // ---------------- counter ----------------
  // a unit may only reset this timer while the timebase select routes it here
  wire use_a  = ctl_reg[tmr3_pkg::CTL_TB_HI];
  wire use_b  = ctl_reg[tmr3_pkg::CTL_TB_HI] | ctl_reg[tmr3_pkg::CTL_TB_LO];
  wire trig_a = CCP_I.trig_a & CCP_I.uses_a & use_a &
                (CCP_I.mode_a == tmr3_pkg::SPEC_TRIG_MODE); // see RL16
  wire trig_b = CCP_I.trig_b & CCP_I.uses_b & use_b &
                (CCP_I.mode_b == tmr3_pkg::SPEC_TRIG_MODE); // see RL16
  wire trig_rst = (trig_a | trig_b) & ~async_mode; // see RL16 RL17
  wire wrap = ps_tick & (count_reg == tmr3_pkg::COUNT_MAX);

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      count_reg <= tmr3_pkg::COUNT_ZERO;
    end else if (wr_lo) begin // see RL18
      count_reg <= wide ? {hi_buf_reg, wbyte} : {count_reg[15:8], wbyte}; // see RL1 RL10
    end else if (wr_hi & ~wide) begin
      count_reg <= {wbyte, count_reg[7:0]}; // see RL1
    end else if (trig_rst) begin
      count_reg <= tmr3_pkg::COUNT_ZERO; // see RL16
    end else if (ps_tick) begin
      count_reg <= count_reg + 16'h0001; // see RL14
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      hi_buf_reg <= 8'h00;
    end else if (wide & wr_hi) begin
      hi_buf_reg <= wbyte; // see RL10 RL11
    end else if (wide & rd_lo) begin
      hi_buf_reg <= count_reg[15:8]; // see RL9
    end
  end

  // flag set beats software clear; trigger path never sets it
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ovf_flag_reg <= 1'b0;
    end else if (wrap & ~wr_lo & ~(wr_hi & ~wide) & ~trig_rst) begin
      ovf_flag_reg <= 1'b1; // see RL14 RL19
    end else if (wr_irq & ~wbyte[tmr3_pkg::IRQ_FLAG]) begin
      ovf_flag_reg <= 1'b0;
    end
  end
  assign OVF_IRQ_O = ovf_flag_reg & ovf_en_reg; // see RL15

  // ---------------- timebase routing ----------------
  wire tb_hi = ctl_reg[tmr3_pkg::CTL_TB_HI];
  wire tb_lo = ctl_reg[tmr3_pkg::CTL_TB_LO];
  assign TBASE_O.count      = count_reg;
  assign TBASE_O.src_a_this = tb_hi; // see RL2
  assign TBASE_O.src_b_this = tb_hi | tb_lo; // see RL2
  assign CCP_A_COUNT_O = TBASE_O.src_a_this ? count_reg : OTHER_COUNT_I;
  assign CCP_B_COUNT_O = TBASE_O.src_b_this ? count_reg : OTHER_COUNT_I;

  // ---------------- assertions ----------------
  a_ctl_reset_zero: assert property (@(posedge MCLK_I)
    $rose(ARST_N_I) |-> ctl_reg == tmr3_pkg::CTL_RESET) // see RL20
    else $error("control not zero after reset");
  a_stop_holds: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (!run && !dp_wr_reg && !trig_rst) |=> $stable(count_reg)) // see RL6
    else $error("counter moved while stopped");
  a_wrap_sets_flag: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (wrap && !dp_wr_reg && !trig_rst) |=> ovf_flag_reg && count_reg == 16'h0000) // see RL14
    else $error("wrap did not set flag");
  a_trig_no_flag: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (trig_rst && !ovf_flag_reg && !dp_wr_reg) |=> !ovf_flag_reg && count_reg == 16'h0000)
    else $error("trigger reset wrong"); // see RL16 RL19
  a_write_beats_trig: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (wr_lo && trig_rst && !wide) |=> count_reg[7:0] == $past(wbyte)) // see RL18
    else $error("trigger beat write");
  a_lo_read_buf: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (wide && rd_lo && !dp_wr_reg) |=> hi_buf_reg == $past(count_reg[15:8])) // see RL9
    else $error("buffer not loaded on low read");
  a_wide_hi_write: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    (wide && wr_hi && !trig_rst && !ps_tick) |=> $stable(count_reg)) // see RL10
    else $error("high write touched counter");
  a_irq_gate: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    OVF_IRQ_O |-> ovf_en_reg && ovf_flag_reg) // see RL15
    else $error("irq without enable");
  a_pins_read_zero: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    aux_osc_en_reg |-> PORT_READ_O == 2'b00 && OSC_PIN_OE_O == 2'b00) // see RL8
    else $error("aux pins not input");
  a_presc_clear: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    wr_lo |=> presc_reg == 3'b000) // see RL12
    else $error("prescaler not cleared");

  // bus checks
  a_hready_always: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL1
    HREADYOUT_O && !HRESP_O)
    else $error("bus not ready or not okay");
  a_hi_read_buf: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL11
    (addr_ph && !HWRITE_I && HADDR_I == tmr3_pkg::ADDR_COUNT_HI && wide)
    |=> HRDATA_O[7:0] == $past(hi_buf_reg))
    else $error("high read bypassed buffer");
  a_hi_write_narrow: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL1
    (!wide && wr_hi) |=> count_reg[15:8] == $past(wbyte))
    else $error("byte high write lost");
  a_lo_write_wide: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL10
    (wide && wr_lo) |=> count_reg == {$past(hi_buf_reg), $past(wbyte)})
    else $error("wide low write did not load both");
  a_presc_hi_keep: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL12
    (wr_hi && !src_tick) |=> $stable(presc_reg))
    else $error("high write touched prescaler");

  // count path checks
  a_run_gates_tick: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL6
    !run |-> !src_tick)
    else $error("tick while stopped");
  a_int_rate: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL7
    (src_tick && !ext) |-> div4_reg == 2'(tmr3_pkg::INSTR_DIV - 1))
    else $error("internal tick off rate");
  a_ext_needs_arm: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL5
    (src_tick && ext) |-> ext_armed_reg)
    else $error("external tick before falling edge");
  a_ext_arm_clear: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL5
    (!ext || !run) |=> !ext_armed_reg)
    else $error("edge arm kept while idle");
  a_count_step: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL14
    (ps_tick && !dp_wr_reg && !trig_rst) |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step by one");
  a_flag_clear: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL14
    (wr_irq && !wbyte[tmr3_pkg::IRQ_FLAG] && !wrap) |=> !ovf_flag_reg)
    else $error("flag clear ignored");
  a_trig_zero: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL16
    (trig_rst && !dp_wr_reg) |=> count_reg == tmr3_pkg::COUNT_ZERO)
    else $error("trigger did not zero counter");
  a_async_no_trig: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL17
    (async_mode && (trig_a || trig_b) && !dp_wr_reg && !ps_tick) |=> $stable(count_reg))
    else $error("trigger acted in async mode");

  // routing, pin and control checks
  a_route_a_this: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL2
    tb_hi |-> CCP_A_COUNT_O == count_reg && CCP_B_COUNT_O == count_reg)
    else $error("unit routing wrong for this timer");
  a_route_b_only: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL2
    (!tb_hi && tb_lo) |-> CCP_A_COUNT_O == OTHER_COUNT_I && CCP_B_COUNT_O == count_reg)
    else $error("split routing wrong");
  a_route_other: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL2
    (!tb_hi && !tb_lo) |-> CCP_A_COUNT_O == OTHER_COUNT_I && CCP_B_COUNT_O == OTHER_COUNT_I)
    else $error("other timer routing wrong");
  a_oe_normal: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL8
    !aux_osc_en_reg |-> OSC_PIN_OE_O == ~PORT_C_DIRECTION_I)
    else $error("pin enable ignores direction");
  a_ctl_write: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // see RL20
    wr_ctl |=> ctl_reg == $past(wbyte))
    else $error("control write lost");

  // main scenarios
  c_wrap: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) wrap);
  c_trig: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) trig_rst);
  c_ext_tick: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) ext_tick && run);
  c_wide_rd: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) wide && rd_lo);
  c_ovf_irq: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) OVF_IRQ_O);
endmodule : tmr3_timer

// >>> verification/tmr3_far_model.sv
// far side model: compare units, other timer and external count source
`timescale 1ns/1ps
module tmr3_far_model (
  // control from bench
  input  wire logic           clk_i,
  input  wire logic           fire_i,
  input  wire logic           go_i,
  input  wire logic [7:0]     pulses_i,
  // toward the timer
  output tmr3_pkg::tmr3_ccp_t ccp_o,
  output logic      [15:0]    other_o,
  output logic                ext_o
);
  logic [7:0] left;
  logic [2:0] ph;
  initial begin
    ccp_o = '0;
    other_o = 16'h0000;
    ext_o = 1'b1;
    left = 8'h00;
    ph = 3'h0;
  end
  always @(posedge clk_i) begin
    other_o <= other_o + 16'h0003;
    ccp_o.mode_a <= 4'hb;
    ccp_o.mode_b <= 4'h2;
    ccp_o.uses_a <= 1'b1;
    ccp_o.trig_a <= fire_i; // one-cycle trigger
    if (go_i) begin
      left <= pulses_i;
    end else if (left != 8'h00) begin
      ph <= ph + 3'h1;
      ext_o <= ph[2]; // fall first, then rise
      if (ph == 3'h7) left <= left - 8'h01;
    end
  end
endmodule : tmr3_far_model

// >>> verification/tb_timer3_counter_16bit.sv
// testbench for the 16-bit timer/counter
`timescale 1ns/1ps
module tb_timer3_counter_16bit;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  hwrite = 1'b0;
  logic                  fire = 1'b0;
  logic                  go = 1'b0;
  logic                  hreadyout, hresp, ovf_irq, ext;
  logic [7:0]            haddr = 8'h00;
  logic [7:0]            pulses = 8'h00;
  logic [1:0]            htrans = 2'h0;
  logic [1:0]            osc_o, osc_oe, port_rd;
  logic [31:0]           hwdata = 32'h0000_0000;
  logic [31:0]           hrdata, rd;
  logic [15:0]           other, a_cnt, b_cnt;
  tmr3_pkg::tmr3_ccp_t   ccp;
  tmr3_pkg::tmr3_tbase_t tbase;
  int                    failures = 0;
  int                    checked = 0;
  always #5 clk = ~clk;
  tmr3_timer tmr3_timer_i (.MCLK_I(clk), .ARST_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .EXT_COUNT_I(ext), .OSC_PIN_I(2'h3), .PORT_C_DIRECTION_I(2'h1), .PORT_OUT_I(2'h2),
    .OSC_PIN_O(osc_o), .OSC_PIN_OE_O(osc_oe), .PORT_READ_O(port_rd), .CCP_I(ccp),
    .OTHER_COUNT_I(other), .TBASE_O(tbase), .CCP_A_COUNT_O(a_cnt), .CCP_B_COUNT_O(b_cnt),
    .OVF_IRQ_O(ovf_irq));
  tmr3_far_model tmr3_far_model_i (.clk_i(clk), .fire_i(fire), .go_i(go), .pulses_i(pulses),
    .ccp_o(ccp), .other_o(other), .ext_o(ext));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= tmr3_pkg::HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask : chk
  task automatic load16(input logic [15:0] v);
    bus(1'b1, tmr3_pkg::ADDR_COUNT_HI, {24'h0000_00, v[15:8]});
    bus(1'b1, tmr3_pkg::ADDR_COUNT_LO, {24'h0000_00, v[7:0]});
  endtask : load16
  task automatic t_reset;
    bus(1'b0, tmr3_pkg::ADDR_CONTROL, 32'h0000_0000);
    chk(rd, 32'h0000_0000, 32'h0000_0000);
    bus(1'b0, 8'h1c, 32'h0000_0000);
    chk(rd, 32'h0000_0000, 32'h0000_0000);
  endtask : t_reset
  task automatic t_wide;
    bus(1'b1, tmr3_pkg::ADDR_COUNT_HI, 32'h0000_0056);
    bus(1'b0, tmr3_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd[15:8], 32'h0000_0056, 32'h0000_0056);
    bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0080);
    bus(1'b1, tmr3_pkg::ADDR_COUNT_HI, 32'h0000_0012);
    bus(1'b0, tmr3_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd[15:8], 32'h0000_0056, 32'h0000_0056);
    bus(1'b1, tmr3_pkg::ADDR_COUNT_LO, 32'h0000_0034);
    bus(1'b0, tmr3_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_1234, 32'h0000_1234);
    bus(1'b1, tmr3_pkg::ADDR_COUNT_HI, 32'h0000_0077);
    bus(1'b0, tmr3_pkg::ADDR_COUNT_LO, 32'h0000_0000);
    chk(rd, 32'h0000_0034, 32'h0000_0034);
    bus(1'b0, tmr3_pkg::ADDR_COUNT_HI, 32'h0000_0000);
    chk(rd, 32'h0000_0012, 32'h0000_0012);
  endtask : t_wide
  task automatic t_presc;
    for (int ps = 0; ps < 4; ps++) begin
      bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0080);
      load16(16'h0000);
      bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0081 | (ps << 4));
      repeat (32 << ps) @(posedge clk);
      bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0080);
      bus(1'b0, tmr3_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0007, 32'h0000_0009);
      repeat (20) @(posedge clk);
      bus(1'b0, tmr3_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0007, 32'h0000_0009);
    end
  endtask : t_presc
  task automatic run_from(input logic [15:0] v, input int cyc);
    bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0080);
    load16(v);
    bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0081);
    repeat (cyc) @(posedge clk);
    bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0080);
    @(negedge clk);
  endtask : run_from
  task automatic t_ovf;
    bus(1'b1, tmr3_pkg::ADDR_IRQ, 32'h0000_0000);
    run_from(16'hfffe, 16);
    chk({31'h0, ovf_irq}, 32'h0000_0000, 32'h0000_0000);
    bus(1'b0, tmr3_pkg::ADDR_IRQ, 32'h0000_0000);
    chk(rd, 32'h0000_0001, 32'h0000_0001);
    bus(1'b0, tmr3_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001, 32'h0000_0004);
    bus(1'b1, tmr3_pkg::ADDR_IRQ, 32'h0000_0002);
    run_from(16'hffff, 12);
    chk({31'h0, ovf_irq}, 32'h0000_0001, 32'h0000_0001);
  endtask : t_ovf
  task automatic t_trig;
    bus(1'b1, tmr3_pkg::ADDR_IRQ, 32'h0000_0002);
    bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0080);
    load16(16'hfff0);
    bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_00c1);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0080);
    bus(1'b0, tmr3_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000, 32'h0000_0002);
    bus(1'b0, tmr3_pkg::ADDR_IRQ, 32'h0000_0000);
    chk(rd, 32'h0000_0002, 32'h0000_0002);
  endtask : t_trig
  task automatic t_tbase;
    load16(16'h1234);
    for (int tb = 0; tb < 4; tb++) begin
      bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0080 | (tb[1] << 6) | (tb[0] << 3));
      @(negedge clk);
      chk(a_cnt, tb[1] ? 16'h1234 : other, tb[1] ? 16'h1234 : other);
      chk(b_cnt, tb != 0 ? 16'h1234 : other, tb != 0 ? 16'h1234 : other);
    end
  endtask : t_tbase
  task automatic t_ext;
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0080);
      load16(16'h0000);
      bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0083 | (s << 2));
      pulses <= 8'h05;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (60) @(posedge clk);
      bus(1'b1, tmr3_pkg::ADDR_CONTROL, 32'h0000_0080);
      bus(1'b0, tmr3_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0005, 32'h0000_0005);
    end
  endtask : t_ext
  task automatic t_aux;
    bus(1'b1, tmr3_pkg::ADDR_AUX, 32'h0000_0001);
    @(negedge clk);
    chk({28'h0, osc_oe, port_rd}, 32'h0000_0000, 32'h0000_0000);
    bus(1'b1, tmr3_pkg::ADDR_AUX, 32'h0000_0000);
    @(negedge clk);
    chk({28'h0, osc_oe, port_rd}, 32'h0000_000b, 32'h0000_000b);
  endtask : t_aux
  task automatic print_verdict;
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_wide();
    t_presc();
    t_ovf();
    t_trig();
    t_tbase();
    t_ext();
    t_aux();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule : tb_timer3_counter_16bit
